// File: rtl/fpsr_flash_protect.sv
`timescale 1ns/10ps
// Functional notes
// (RULE1) Security register is read-only; writes ignored.
// (RULE2) Security register loaded from nonvolatile field during reset sequence.
// (RULE3) Backdoor key enable bits 7:6 enabled only for encoding 10.
// (RULE4) Security bits 1:0: 10 unsecured, 00 and 01 secured.
// (RULE5) Security encoding 11 also secured.
// (RULE6) Successful backdoor key access forces security field to unsecured.
// (RULE7) Reserved test register reads zero, ignores writes.
// (RULE8) Config register: only bits 7,6,5 writable, rest zero, reset zero.
// (RULE9) Key-access bit writable only while backdoor key enabled.
// (RULE10) Key-access clear: array writes start commands; set: they are keys.
// (RULE11) Array reads remain allowed while key-access is set.
// (RULE12) Bit 7 set requests interrupt while buffer-empty flag set.
// (RULE13) Bit 6 set requests interrupt while command-complete flag set.
// (RULE14) Normal mode: protection write accepted only if protection grows.
// (RULE15) Special mode: protection register freely writable.
// (RULE16) Protection register loaded from nonvolatile byte during reset.
// (RULE17) Software unprotects config sector before reprogramming protection byte.
// (RULE18) Program or erase in protected range refused, violation flag set.
// (RULE19) Mass erase refused if any sector protected.
// (RULE20) Upper field n protects (n+1)*0x400 to 0x7FFF; 0x1F none.
// (RULE21) Lower field selects protected size from array base.
// (RULE22) Lower: 000 all, 011..110 4..1 KB, 111 none, 001/010 as 000.
// (RULE23) Violation flag cleared by writing one; blocks command launch while set.
module fpsr_flash_protect
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic [8:0]  addr,
  input  wire logic [7:0]  wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [7:0]  rdata,
  input  wire logic [7:0]  nv_security,
  input  wire logic [7:0]  nv_protection,
  input  wire logic        special_mode,
  input  wire logic        buffer_empty_flag,
  input  wire logic        command_complete_flag,
  input  wire logic        backdoor_unlock,
  input  wire logic        array_wr,
  input  wire logic        array_rd,
  input  wire logic [14:0] array_addr,
  input  wire logic        cmd_valid,
  input  wire logic [1:0]  cmd_kind,
  input  wire logic [14:0] cmd_addr,
  output logic             cmd_launch,
  output logic             cmd_refused,
  output logic             seq_start,
  output logic             key_write,
  output logic             array_rd_ok,
  output logic             irq,
  output logic             secured,
  output logic             key_enabled,
  output logic             protection_violation_flag
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    FPSR_LOAD,
    FPSR_RUN
  } fpsr_phase_t;

  fpsr_phase_t phase_r;
  logic [7:0]  security_state_reg_r;
  logic [7:0]  irq_and_key_config_reg_r;
  logic [7:0]  sector_protection_reg_r;
  logic [7:0]  prot_nxt;
  logic        backdoor_key_enable;
  logic [4:0]  upper_protect_size;
  logic [2:0]  lower_protect_size;
  logic [15:0] upper_base;
  logic [14:0] lower_last;
  logic        lower_on;
  logic        upper_on;
  logic        any_prot;
  logic        in_prot;
  logic        cmd_bad;
  logic        grows;
  logic        wr_sec;
  logic        wr_cnfg;
  logic        wr_prot;
  logic        wr_stat;

  assign wr_sec  = wr && (addr == fpsr_pkg::OFF_SEC);
  assign wr_cnfg = wr && (addr == fpsr_pkg::OFF_CNFG);
  assign wr_prot = wr && (addr == fpsr_pkg::OFF_PROT);
  assign wr_stat = wr && (addr == fpsr_pkg::OFF_STAT);

  assign backdoor_key_enable =
    security_state_reg_r[fpsr_pkg::BACKDOOR_KEY_ENABLE_HI:fpsr_pkg::BACKDOOR_KEY_ENABLE_LO] == fpsr_pkg::BACKDOOR_KEY_ENABLE_ON; // RULE3
  assign upper_protect_size =
    sector_protection_reg_r[fpsr_pkg::UPS_HI:fpsr_pkg::UPS_LO];
  assign lower_protect_size =
    sector_protection_reg_r[fpsr_pkg::LPS_HI:fpsr_pkg::LPS_LO];

  // ----------------------------------------------------------------
  // Protected range decode
  // ----------------------------------------------------------------
  always_comb
  begin
    upper_on   = upper_protect_size != fpsr_pkg::UPS_NONE; // RULE20
    upper_base = ({11'h000, upper_protect_size} + 16'h0001) * {1'b0, fpsr_pkg::SECTOR_SIZE};
    lower_on   = lower_protect_size != fpsr_pkg::LPS_NONE; // RULE21
    if (lower_protect_size < fpsr_pkg::LPS_4K)
    begin
      lower_last = fpsr_pkg::ARRAY_TOP; // RULE22
    end
    else
    begin
      lower_last = 15'((fpsr_pkg::LPS_NONE - lower_protect_size) * 15'h0400 - 15'h0001); // RULE22
    end
    any_prot = upper_on || lower_on;
    in_prot  = (upper_on && ({1'b0, cmd_addr} >= upper_base))
            || (lower_on && (cmd_addr <= lower_last)); // RULE18
    cmd_bad  = (cmd_kind == fpsr_pkg::FPSR_CMD_MASS) ? any_prot : in_prot; // RULE19
  end

  // Protected size grows when no range shrinks
  always_comb
  begin
    prot_nxt = wdata;
    grows = (wdata[fpsr_pkg::UPS_HI:fpsr_pkg::UPS_LO] <= upper_protect_size)
         && ((wdata[fpsr_pkg::LPS_HI:fpsr_pkg::LPS_LO] < fpsr_pkg::LPS_4K)
          || (lower_protect_size >= fpsr_pkg::LPS_4K
              && wdata[fpsr_pkg::LPS_HI:fpsr_pkg::LPS_LO] <= lower_protect_size));
  end

  // ----------------------------------------------------------------
  // Reset sequence load
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      phase_r <= FPSR_LOAD;
    else
      phase_r <= FPSR_RUN;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      security_state_reg_r <= fpsr_pkg::SEC_RESET;
    else if (phase_r == FPSR_LOAD)
      security_state_reg_r <= nv_security & 8'hC3; // RULE2
    else if (backdoor_unlock && backdoor_key_enable)
      security_state_reg_r[fpsr_pkg::SEC_HI:fpsr_pkg::SEC_LO] <= fpsr_pkg::SEC_UNSECURE; // RULE6
  end
  // Software writes to wr_sec have no path into the register // RULE1

  always_ff @(posedge clk)
  begin
    if (reset)
      sector_protection_reg_r <= fpsr_pkg::PROT_RESET;
    else if (phase_r == FPSR_LOAD)
      sector_protection_reg_r <= nv_protection; // RULE16
    else if (wr_prot && (special_mode || grows)) // RULE14
      sector_protection_reg_r <= prot_nxt; // RULE15
  end

  // ----------------------------------------------------------------
  // Configuration register
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      irq_and_key_config_reg_r <= fpsr_pkg::CNFG_RESET; // RULE8
    else if (wr_cnfg)
    begin
      irq_and_key_config_reg_r[fpsr_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT] <= wdata[fpsr_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT]; // RULE8
      irq_and_key_config_reg_r[fpsr_pkg::COMPLETE_IRQ_ENABLE_BIT]  <= wdata[fpsr_pkg::COMPLETE_IRQ_ENABLE_BIT];
      if (backdoor_key_enable)
        irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT] <= wdata[fpsr_pkg::KEY_WRITE_ACCESS_BIT]; // RULE9
    end
  end

  // ----------------------------------------------------------------
  // Violation flag and command gate
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      protection_violation_flag <= 1'b0;
    else if (cmd_valid && !protection_violation_flag && cmd_bad)
      protection_violation_flag <= 1'b1; // RULE18
    else if (wr_stat && wdata[fpsr_pkg::STAT_PROTECTION_VIOLATION_FLAG])
      protection_violation_flag <= 1'b0; // RULE23
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      cmd_launch  <= 1'b0;
      cmd_refused <= 1'b0;
    end
    else
    begin
      cmd_launch  <= cmd_valid && !protection_violation_flag && !cmd_bad; // RULE23
      cmd_refused <= cmd_valid && (protection_violation_flag || cmd_bad); // RULE19
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      seq_start   <= 1'b0;
      key_write   <= 1'b0;
      array_rd_ok <= 1'b0;
    end
    else
    begin
      seq_start   <= array_wr && !irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT]
                     && !protection_violation_flag; // RULE10
      key_write   <= array_wr && irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT]; // RULE10
      array_rd_ok <= array_rd; // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Status outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      irq         <= 1'b0;
      secured     <= 1'b1;
      key_enabled <= 1'b0;
    end
    else
    begin
      irq <= (irq_and_key_config_reg_r[fpsr_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT] && buffer_empty_flag) // RULE12
          || (irq_and_key_config_reg_r[fpsr_pkg::COMPLETE_IRQ_ENABLE_BIT] && command_complete_flag); // RULE13
      secured <= security_state_reg_r[fpsr_pkg::SEC_HI:fpsr_pkg::SEC_LO]
                 != fpsr_pkg::SEC_UNSECURE; // RULE4 RULE5
      key_enabled <= backdoor_key_enable;
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
      rdata <= 8'h00;
    else if (rd)
    begin
      if (addr == fpsr_pkg::OFF_SEC)
        rdata <= security_state_reg_r;
      else if (addr == fpsr_pkg::OFF_RSV0)
        rdata <= 8'h00; // RULE7
      else if (addr == fpsr_pkg::OFF_CNFG)
        rdata <= irq_and_key_config_reg_r & fpsr_pkg::CNFG_MASK; // RULE8
      else if (addr == fpsr_pkg::OFF_PROT)
        rdata <= sector_protection_reg_r;
      else if (addr == fpsr_pkg::OFF_STAT)
        rdata <= {buffer_empty_flag, command_complete_flag, protection_violation_flag, 5'h00};
      else
        rdata <= 8'h00;
    end
    else
      rdata <= 8'h00;
  end

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_sec_ro;
    @(posedge clk) disable iff (reset)
    (phase_r == FPSR_RUN && wr_sec && !backdoor_unlock) |=> $stable(security_state_reg_r);
  endproperty
  a_sec_ro: assert property (p_sec_ro) else $error("security reg changed by write"); // RULE1

  property p_load;
    @(posedge clk) disable iff (reset)
    (phase_r == FPSR_LOAD) |=> (sector_protection_reg_r == $past(nv_protection));
  endproperty
  a_load: assert property (p_load) else $error("protection not loaded"); // RULE16

  property p_key_write_access;
    @(posedge clk) disable iff (reset)
    (wr_cnfg && !backdoor_key_enable) |=>
      $stable(irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT]);
  endproperty
  a_key_write_access: assert property (p_key_write_access) else $error("key access written while disabled"); // RULE9

  property p_unlock;
    @(posedge clk) disable iff (reset)
    (phase_r == FPSR_RUN && backdoor_unlock && backdoor_key_enable) |=> ##1 !secured;
  endproperty
  a_unlock: assert property (p_unlock) else $error("unlock did not unsecure"); // RULE6

  property p_shrink;
    @(posedge clk) disable iff (reset)
    (phase_r == FPSR_RUN && wr_prot && !special_mode && !grows) |=>
      $stable(sector_protection_reg_r);
  endproperty
  a_shrink: assert property (p_shrink) else $error("protection shrank"); // RULE14

  property p_viol;
    @(posedge clk) disable iff (reset)
    (cmd_valid && cmd_bad && !protection_violation_flag) |=>
      (protection_violation_flag && cmd_refused && !cmd_launch);
  endproperty
  a_viol: assert property (p_viol) else $error("violation not flagged"); // RULE18

  property p_block;
    @(posedge clk) disable iff (reset)
    protection_violation_flag |=> !cmd_launch && !seq_start;
  endproperty
  a_block: assert property (p_block) else $error("launch while violation set"); // RULE23

  sequence s_irq_cause;
    irq_and_key_config_reg_r[fpsr_pkg::COMPLETE_IRQ_ENABLE_BIT] && command_complete_flag;
  endsequence
  property p_irq;
    @(posedge clk) disable iff (reset)
    s_irq_cause |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("complete irq missing"); // RULE13

  property p_rsv;
    @(posedge clk) disable iff (reset)
    (rd && addr == fpsr_pkg::OFF_RSV0) |=> (rdata == 8'h00);
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved reg nonzero"); // RULE7

  property p_cfg_rd;
    @(posedge clk) disable iff (reset)
    (rd && addr == fpsr_pkg::OFF_CNFG) |=> ((rdata & ~fpsr_pkg::CNFG_MASK) == 8'h00);
  endproperty
  a_cfg_rd: assert property (p_cfg_rd) else $error("config unused bits nonzero"); // RULE8

  sequence s_buf_cause;
    irq_and_key_config_reg_r[fpsr_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT] && buffer_empty_flag;
  endsequence
  property p_irq_buf;
    @(posedge clk) disable iff (reset)
    s_buf_cause |=> irq;
  endproperty
  a_irq_buf: assert property (p_irq_buf) else $error("buffer empty irq missing"); // RULE12

  property p_irq_off;
    @(posedge clk) disable iff (reset)
    (!(irq_and_key_config_reg_r[fpsr_pkg::BUFFER_EMPTY_IRQ_ENABLE_BIT] && buffer_empty_flag)
      && !(irq_and_key_config_reg_r[fpsr_pkg::COMPLETE_IRQ_ENABLE_BIT] && command_complete_flag)) |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("irq without enabled cause"); // RULE13

  property p_key_wr;
    @(posedge clk) disable iff (reset)
    (array_wr && irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT]) |=> (key_write && !seq_start);
  endproperty
  a_key_wr: assert property (p_key_wr) else $error("array write not taken as key"); // RULE10

  property p_seq;
    @(posedge clk) disable iff (reset)
    (array_wr && !irq_and_key_config_reg_r[fpsr_pkg::KEY_WRITE_ACCESS_BIT]
      && !protection_violation_flag) |=> (seq_start && !key_write);
  endproperty
  a_seq: assert property (p_seq) else $error("array write did not start sequence"); // RULE10

  property p_rd_ok;
    @(posedge clk) disable iff (reset)
    array_rd |=> array_rd_ok;
  endproperty
  a_rd_ok: assert property (p_rd_ok) else $error("array read blocked"); // RULE11

  property p_mass;
    @(posedge clk) disable iff (reset)
    (cmd_valid && cmd_kind == fpsr_pkg::FPSR_CMD_MASS && any_prot) |=>
      (cmd_refused && !cmd_launch);
  endproperty
  a_mass: assert property (p_mass) else $error("mass erase launched while protected"); // RULE19

  property p_sec_load;
    @(posedge clk) disable iff (reset)
    (phase_r == FPSR_LOAD) |=> (security_state_reg_r == ($past(nv_security) & 8'hC3));
  endproperty
  a_sec_load: assert property (p_sec_load) else $error("security not loaded"); // RULE2

endmodule

// File: rtl/fpsr_pkg.sv
package fpsr_pkg;
  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [8:0] OFF_SEC   = 9'h101;
  localparam logic [8:0] OFF_RSV0  = 9'h102;
  localparam logic [8:0] OFF_CNFG  = 9'h103;
  localparam logic [8:0] OFF_PROT  = 9'h104;
  localparam logic [8:0] OFF_STAT  = 9'h105;
  localparam logic [8:0] OFF_MODE  = 9'h110;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BACKDOOR_KEY_ENABLE_HI   = 7;
  localparam int BACKDOOR_KEY_ENABLE_LO   = 6;
  localparam int SEC_HI     = 1;
  localparam int SEC_LO     = 0;
  localparam int BUFFER_EMPTY_IRQ_ENABLE_BIT  = 7;
  localparam int COMPLETE_IRQ_ENABLE_BIT   = 6;
  localparam int KEY_WRITE_ACCESS_BIT = 5;
  localparam int UPS_HI     = 7;
  localparam int UPS_LO     = 3;
  localparam int LPS_HI     = 2;
  localparam int LPS_LO     = 0;
  localparam int STAT_BUFFER_EMPTY_FLAG = 7;
  localparam int STAT_COMMAND_COMPLETE_FLAG  = 6;
  localparam int STAT_PROTECTION_VIOLATION_FLAG = 5;

  // ----------------------------------------------------------------
  // Encodings and reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] BACKDOOR_KEY_ENABLE_ON     = 2'h2;
  localparam logic [1:0] SEC_UNSECURE = 2'h2;
  localparam logic [7:0] CNFG_RESET   = 8'h00;
  localparam logic [7:0] CNFG_MASK    = 8'hE0;
  localparam logic [7:0] SEC_RESET    = 8'h00;
  localparam logic [7:0] PROT_RESET   = 8'h00;
  localparam logic [4:0] UPS_NONE     = 5'h1F;
  localparam logic [2:0] LPS_NONE     = 3'h7;
  localparam logic [2:0] LPS_4K       = 3'h3;

  // ----------------------------------------------------------------
  // Array geometry
  // ----------------------------------------------------------------
  localparam logic [14:0] SECTOR_SIZE = 15'h0400;
  localparam logic [14:0] ARRAY_TOP   = 15'h7FFF;

  typedef enum logic [1:0] {
    FPSR_CMD_PROGRAM,
    FPSR_CMD_ERASE,
    FPSR_CMD_MASS
  } fpsr_cmd_t;
endpackage

// File: tb/tb_top.sv
`timescale 1ns/10ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin n_mismatch++; \
  $display("[ERR] t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_top;
  localparam logic [8:0] A_SEC = fpsr_pkg::OFF_SEC;
  localparam logic [8:0] A_RSV = fpsr_pkg::OFF_RSV0;
  localparam logic [8:0] A_CFG = fpsr_pkg::OFF_CNFG;
  localparam logic [8:0] A_PRT = fpsr_pkg::OFF_PROT;
  localparam logic [8:0] A_STA = fpsr_pkg::OFF_STAT;
  logic clk = 1'b0, reset = 1'b1, wr = 1'b0, rd = 1'b0, special_mode = 1'b0;
  logic buffer_empty_flag = 1'b0, command_complete_flag = 1'b0, backdoor_unlock = 1'b0;
  logic array_wr = 1'b0, array_rd = 1'b0, cmd_valid = 1'b0;
  logic [8:0] addr = 9'h000;
  logic [7:0] wdata = 8'h00, nv_security = 8'h00, nv_protection = 8'hFF, rdata;
  logic [14:0] array_addr = 15'h0000, cmd_addr = 15'h0000;
  logic [1:0] cmd_kind = 2'h0;
  logic cmd_launch, cmd_refused, seq_start, key_write, array_rd_ok, irq, secured, key_enabled;
  logic protection_violation_flag;
  int n_mismatch = 0, n_checks = 0, cyc = 0;
  always #50 clk = ~clk;
  fpsr_flash_protect dut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .nv_security(nv_security), .nv_protection(nv_protection),
    .special_mode(special_mode), .buffer_empty_flag(buffer_empty_flag),
    .command_complete_flag(command_complete_flag), .backdoor_unlock(backdoor_unlock),
    .array_wr(array_wr), .array_rd(array_rd), .array_addr(array_addr),
    .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_addr(cmd_addr),
    .cmd_launch(cmd_launch), .cmd_refused(cmd_refused), .seq_start(seq_start),
    .key_write(key_write), .array_rd_ok(array_rd_ok), .irq(irq), .secured(secured),
    .key_enabled(key_enabled), .protection_violation_flag(protection_violation_flag));
  // --------------------------------------------------------------
  // Bus and pin helpers
  // --------------------------------------------------------------
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic wr_reg(input logic [8:0] a, input logic [7:0] d);
    @(posedge clk); addr <= a; wdata <= d; wr <= 1'b1;
    @(posedge clk); wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [8:0] a, input logic [7:0] e);
    @(posedge clk); addr <= a; rd <= 1'b1;
    @(posedge clk); rd <= 1'b0;
    #1 `CHK(rdata, e)
    @(posedge clk);
    #1 `CHK(rdata, 8'h00)
  endtask
  task automatic do_reset(input logic [7:0] sec, input logic [7:0] prot);
    @(posedge clk); reset <= 1'b1; nv_security <= sec; nv_protection <= prot;
    repeat (5) @(posedge clk);
    #1 `CHK(secured, 1'b1)
    @(posedge clk); reset <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic cmd_chk(input logic [1:0] k, input logic [14:0] a, input logic ok);
    @(posedge clk); cmd_valid <= 1'b1; cmd_kind <= k; cmd_addr <= a; array_addr <= a;
    @(posedge clk); cmd_valid <= 1'b0;
    #1 `CHK(cmd_launch, ok)
    `CHK(cmd_refused, ~ok)
    `CHK(protection_violation_flag, ~ok)
  endtask
  task automatic clr_flag();
    rd_chk(A_STA, 8'h20);
    wr_reg(A_STA, 8'h20);
    rd_chk(A_STA, 8'h00);
  endtask
  task automatic arr(input logic w, input logic kw, input logic ss);
    @(posedge clk); array_wr <= w; array_rd <= ~w;
    @(posedge clk); array_wr <= 1'b0; array_rd <= 1'b0;
    #1 `CHK(key_write, kw)
    `CHK(seq_start, ss)
    `CHK(array_rd_ok, ~w)
  endtask
  task automatic wait_irq(input logic be, input logic cc, input logic e);
    @(posedge clk); buffer_empty_flag <= be; command_complete_flag <= cc;
    repeat (2) @(posedge clk);
    #1 `CHK(irq, e)
  endtask
  function automatic int low_lim(input int c);
    if (c < 3)
      return 32'h8000;
    if (c == 7)
      return 0;
    return (7 - c) * 32'h400;
  endfunction
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_sec_codes();
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
    begin
      v = {i[1:0], 4'h0, i[1:0]};
      do_reset(v, 8'hFF);
      `CHK(key_enabled, i == 2)
      `CHK(secured, i != 2)
      wr_reg(A_SEC, ~v);
      rd_chk(A_SEC, v);
    end
  endtask
  task automatic t_backdoor();
    do_reset(8'h81, 8'hFF);
    @(posedge clk); backdoor_unlock <= 1'b1;
    @(posedge clk); backdoor_unlock <= 1'b0;
    @(posedge clk);
    #1 `CHK(secured, 1'b0)
    rd_chk(A_SEC, 8'h82);
  endtask
  task automatic t_config();
    rd_chk(A_CFG, 8'h00);
    wr_reg(A_CFG, 8'hFF);
    rd_chk(A_CFG, 8'hE0);
    wr_reg(A_RSV, 8'hFF);
    rd_chk(A_RSV, 8'h00);
    rd_chk(9'h1FF, 8'h00);
    arr(1'b1, 1'b1, 1'b0);
    arr(1'b0, 1'b0, 1'b0);
    wr_reg(A_CFG, 8'h80);
    arr(1'b1, 1'b0, 1'b1);
    wait_irq(1'b1, 1'b0, 1'b1);
    wait_irq(1'b0, 1'b1, 1'b0);
    wr_reg(A_CFG, 8'h40);
    wait_irq(1'b0, 1'b1, 1'b1);
    wr_reg(A_CFG, 8'h00);
    wait_irq(1'b1, 1'b1, 1'b0);
    wait_irq(1'b0, 1'b0, 1'b0);
    do_reset(8'h41, 8'hFF);
    wr_reg(A_CFG, 8'hFF);
    rd_chk(A_CFG, 8'hC0);
  endtask
  task automatic t_protect();
    logic [14:0] b;
    do_reset(8'h82, 8'hFF);
    rd_chk(A_PRT, 8'hFF);
    wr_reg(A_PRT, 8'h7F);
    rd_chk(A_PRT, 8'h7F);
    wr_reg(A_PRT, 8'hFF);
    rd_chk(A_PRT, 8'h7F);
    cmd_chk(2'h0, 15'h4000, 1'b0);
    cmd_chk(2'h0, 15'h3FFF, 1'b0);
    arr(1'b1, 1'b0, 1'b0);
    clr_flag();
    cmd_chk(2'h0, 15'h3FFF, 1'b1);
    cmd_chk(2'h2, 15'h0000, 1'b0);
    clr_flag();
    cmd_chk(2'h1, 15'h7FFF, 1'b0);
    clr_flag();
    @(posedge clk); special_mode <= 1'b1;
    wr_reg(A_PRT, 8'hFF);
    rd_chk(A_PRT, 8'hFF);
    cmd_chk(2'h2, 15'h0000, 1'b1);
    cmd_chk(2'h0, 15'h7FFF, 1'b1);
    for (int c = 0; c < 8; c++)
    begin
      wr_reg(A_PRT, {5'h1F, c[2:0]});
      b = 15'(low_lim(c) - 1);
      if (low_lim(c) != 0)
      begin
        cmd_chk(2'h0, b, 1'b0);
        clr_flag();
      end
      if (low_lim(c) < 32'h8000)
        cmd_chk(2'h0, 15'(low_lim(c)), 1'b1);
    end
    for (int n = 0; n < 31; n += 15)
    begin
      wr_reg(A_PRT, {n[4:0], 3'h7});
      b = 15'((n + 1) * 32'h400);
      cmd_chk(2'h0, b, 1'b0);
      clr_flag();
      cmd_chk(2'h0, b - 15'h0001, 1'b1);
    end
    @(posedge clk); special_mode <= 1'b0;
  endtask
  // --------------------------------------------------------------
  // Run control
  // --------------------------------------------------------------
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  initial
  begin
    t_sec_codes();
    t_backdoor();
    t_config();
    t_protect();
    close_out();
  end
endmodule
